// ===== vsb_pkg.sv
// Purpose: shared constants and types for the serial bridge.
// Assumes: 10 MHz system clock, 32-bit register bus.
// Notes: all offsets are byte addresses.
package vsb_pkg;
  localparam int unsigned CLK_HZ = 10000000; // system clock rate in hz
  localparam int unsigned CLK_NS = 100; // clock period in ns
  localparam int DIV_W = 12; // bit-period counter width
  localparam int BAUD_W = 20; // width of the stored bit rate
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // handshake mode, socket flag
  localparam logic [7:0] OFF_BAUD = 8'h04; // bit rate in bit/s
  localparam logic [7:0] OFF_STAT = 8'h08; // live status
  localparam logic [7:0] OFF_DATA_USB = 8'h0c; // usb channel data
  localparam logic [7:0] OFF_DATA_NET = 8'h10; // socket channel data
  // field positions
  localparam int CTRL_MODE_LSB = 0; // two-bit handshake mode
  localparam int CTRL_SOCK_BIT = 2; // socket channel connected
  localparam int STAT_RXFULL_BIT = 0; // input buffer holds a byte
  localparam int STAT_TXFULL_BIT = 1; // outgoing byte waiting
  localparam int STAT_TXBUSY_BIT = 2; // serializer busy
  localparam int STAT_OVR_BIT = 3; // byte lost on a full buffer, write 1 clears
  localparam int STAT_EN_BIT = 4; // level of the bridge enable pin
  localparam int STAT_RTS_BIT = 5; // level of the request-to-send pin
  localparam int STAT_PORT_LSB = 16; // socket port number field
  localparam logic [15:0] NET_PORT = 16'h1325; // socket port 4901
  // reset values
  localparam logic [BAUD_W-1:0] BAUD_RESET = 20'h1c200; // 115200 bit/s
  localparam logic [1:0] MODE_RESET = 2'h0; // handshake disabled
  localparam logic [BAUD_W-1:0] BAUD_MIN = 20'h02580; // 9600 bit/s
  localparam logic [BAUD_W-1:0] BAUD_MAX = 20'he1000; // 921600 bit/s
  // handshake modes: bit 0 drives clear-to-send, bit 1 honours request-to-send
  typedef enum logic [1:0] {
    VSB_HS_OFF = 2'h0,
    VSB_HS_RTS = 2'h1,
    VSB_HS_CTS = 2'h2,
    VSB_HS_BOTH = 2'h3
  } vsb_mode_t;
  // serial engine states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    VSB_IDLE = 2'h0,
    VSB_START = 2'h1,
    VSB_DATA = 2'h3,
    VSB_STOP = 2'h2
  } vsb_state_t;

  // clock cycles per bit for a supported rate, zero when unsupported
  function automatic logic [DIV_W-1:0] vsb_div(input logic [BAUD_W-1:0] rate);
    int unsigned r;
    r = 0;
    case (rate)
      20'h02580, 20'h04b00, 20'h09600, 20'h0e100,
      20'h1c200, 20'h38400, 20'h70800, 20'he1000: r = (CLK_HZ + rate / 2) / rate;
      default: r = 0;
    endcase
    return r[DIV_W-1:0];
  endfunction
endpackage

// ===== vsb_tx_if.sv
// Purpose: byte handoff from the bridge core to its serializer.
// Assumes: single clock domain.
// Notes: a byte moves on a cycle with valid and ready both high.
`timescale 1ns/1ps
interface vsb_tx_if;
  import vsb_pkg::*;
  logic valid; // byte offered
  logic ready; // serializer idle
  logic [7:0] data; // byte to send
  logic [DIV_W-1:0] div; // cycles per bit
  modport src (output valid, output data, output div, input ready);
  modport ser (input valid, input data, input div, output ready);
endinterface

// ===== vsb_uart_tx.sv
// Purpose: serializer for bytes toward the target.
// Assumes: div is at least 2 and stable while a character is sent.
// Notes: a character once started always runs to its stop bit.
`timescale 1ns/1ps
module vsb_uart_tx
  import vsb_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  vsb_tx_if.ser tx, // byte handoff
  output logic txd // serial line to the target
);
  typedef struct packed {
    vsb_state_t st; // frame position
    logic [DIV_W-1:0] cnt; // cycles left in this bit
    logic [2:0] bitn; // data bit index
    logic [7:0] shf; // bits still to send
    logic line; // registered line level
  } vsb_txs_t;

  vsb_txs_t s_reg; // current state
  vsb_txs_t s_next; // next state

  assign tx.ready = (s_reg.st == VSB_IDLE);
  assign txd = s_reg.line;

  // frame sequencer: low start, data lsb first, high stop
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      VSB_IDLE: begin
        s_next.line = 1'b1; // idle high
        if (tx.valid) begin
          s_next.st = VSB_START;
          s_next.line = 1'b0;
          s_next.shf = tx.data;
          s_next.cnt = tx.div - 1'b1;
          s_next.bitn = 3'h0;
        end
      end
      VSB_START: begin
        if (s_reg.cnt == '0) begin
          s_next.st = VSB_DATA;
          s_next.line = s_reg.shf[0];
          s_next.shf = {1'b0, s_reg.shf[7:1]};
          s_next.cnt = tx.div - 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      VSB_DATA: begin
        if (s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else if (s_reg.bitn == 3'h7) begin
          s_next.st = VSB_STOP;
          s_next.line = 1'b1;
          s_next.cnt = tx.div - 1'b1;
        end else begin
          s_next.bitn = s_reg.bitn + 1'b1;
          s_next.line = s_reg.shf[0];
          s_next.shf = {1'b0, s_reg.shf[7:1]};
          s_next.cnt = tx.div - 1'b1;
        end
      end
      VSB_STOP: begin
        // byte in flight is never aborted, whatever the far end signals
        if (s_reg.cnt == '0) begin
          s_next.st = VSB_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      default: begin
        s_next.st = VSB_IDLE;
        s_next.line = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{st: VSB_IDLE, cnt: '0, bitn: 3'h0, shf: 8'h00, line: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ===== vsb_bridge.sv
// Purpose: serial bridge core between a target uart and two host channels.
// Assumes: AHB-Lite single word transfers, zero wait states.
// Notes: one-byte input buffer; clear-to-send follows its fill state.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module vsb_bridge
  import vsb_pkg::*;
(
  input wire logic hclk, // system clock, 10 mhz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready, never stalls
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic rxd, // serial data from the target
  output logic txd, // serial data to the target
  output logic cts_o, // clear-to-send level toward the target
  output logic cts_oe, // clear-to-send driven when high
  input wire logic rts_n_free, // target request-to-send, high = may send
  input wire logic vcom_en // bridge enable from the target
);
  typedef struct packed {
    logic [1:0] mode; // handshake mode
    logic sock; // socket channel connected
    logic [BAUD_W-1:0] baud; // bit rate
    logic [DIV_W-1:0] div; // cycles per bit
    vsb_state_t rx_st; // receiver position
    logic [DIV_W-1:0] rx_cnt; // cycles to next sample
    logic [2:0] rx_bit; // data bit index
    logic [7:0] rx_shf; // assembling byte
    logic [7:0] rx_buf; // input buffer
    logic rx_full; // input buffer occupied
    logic ovr; // byte lost
    logic [7:0] tx_buf; // byte waiting for the serializer
    logic tx_full; // tx_buf occupied
    logic ph_wr; // pending write data phase
    logic [7:0] ph_addr; // its address
    logic [31:0] rdata; // read data for the data phase
    logic cfg_touched; // config written since reset
  } vsb_st_t;

  localparam logic [DIV_W-1:0] DIV_RESET = vsb_div(BAUD_RESET);

  // elaboration guards: the serializer needs at least a few cycles per bit
  if (vsb_div(BAUD_MAX) < 4) begin : g_chk_fast
    $error("clock too slow for the top bit rate");
  end
  // a zero divisor would mean the slowest rate overflows the bit counter
  if (vsb_div(BAUD_MIN) == 0) begin : g_chk_slow
    $error("divider too narrow for the lowest rate");
  end

  vsb_st_t s_reg; // current state
  vsb_st_t s_next; // next state
  vsb_tx_if txl (); // link to the serializer

  logic addr_ok; // valid address phase this cycle
  logic [7:0] aoff; // word offset of the address phase
  logic [7:0] act_off; // data register of the live channel
  logic pop; // read of the live channel data register
  logic rx_store; // receiver finished a good frame
  logic hon_rts; // request-to-send honoured
  logic [31:0] stat_w; // status word

  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign aoff = {haddr[7:2], 2'b00};
  assign act_off = s_reg.sock ? OFF_DATA_NET : OFF_DATA_USB;
  assign pop = addr_ok && !hwrite && (aoff == act_off) && s_reg.rx_full;
  assign hon_rts = s_reg.mode[1];
  assign rx_store = (s_reg.rx_st == VSB_STOP) && (s_reg.rx_cnt == '0) && rxd && vcom_en;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign cts_o = !s_reg.rx_full;
  assign cts_oe = s_reg.mode[0];
  // byte offered while enabled and, if honoured, while the target permits
  assign txl.valid = s_reg.tx_full && vcom_en && (!hon_rts || rts_n_free);
  assign txl.data = s_reg.tx_buf;
  assign txl.div = s_reg.div;

  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[STAT_RXFULL_BIT] = s_reg.rx_full;
    stat_w[STAT_TXFULL_BIT] = s_reg.tx_full;
    stat_w[STAT_TXBUSY_BIT] = !txl.ready;
    stat_w[STAT_OVR_BIT] = s_reg.ovr;
    stat_w[STAT_EN_BIT] = vcom_en;
    stat_w[STAT_RTS_BIT] = rts_n_free;
    stat_w[STAT_PORT_LSB +: 16] = NET_PORT;
  end

  // bus slave, receiver and buffers
  always_comb begin
    s_next = s_reg;
    // bus address phase: latch writes, prepare read data
    s_next.ph_wr = addr_ok && hwrite;
    s_next.ph_addr = aoff;
    if (addr_ok && !hwrite) begin
      case (aoff)
        OFF_CTRL: s_next.rdata = {29'h0, s_reg.sock, s_reg.mode};
        OFF_BAUD: s_next.rdata = {12'h000, s_reg.baud};
        OFF_STAT: s_next.rdata = stat_w;
        OFF_DATA_USB, OFF_DATA_NET: begin
          // inactive channel sees nothing
          s_next.rdata = (aoff == act_off) ? {23'h0, s_reg.rx_full, s_reg.rx_buf} : 32'h0;
        end
        default: s_next.rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    // data phase of a write
    if (s_reg.ph_wr) begin
      case (s_reg.ph_addr)
        OFF_CTRL: begin
          s_next.mode = hwdata[CTRL_MODE_LSB +: 2];
          s_next.sock = hwdata[CTRL_SOCK_BIT];
          s_next.cfg_touched = 1'b1;
        end
        OFF_BAUD: begin
          // unsupported rates are ignored, keeping the old one
          if (vsb_div(hwdata[BAUD_W-1:0]) != '0) begin
            s_next.baud = hwdata[BAUD_W-1:0];
            s_next.div = vsb_div(hwdata[BAUD_W-1:0]);
          end
          s_next.cfg_touched = 1'b1;
        end
        OFF_STAT: begin
          if (hwdata[STAT_OVR_BIT]) s_next.ovr = 1'b0;
        end
        OFF_DATA_USB, OFF_DATA_NET: begin
          // only the live channel may send; a full holding byte drops it
          if (s_reg.ph_addr == act_off && !s_reg.tx_full) begin
            s_next.tx_buf = hwdata[7:0];
            s_next.tx_full = 1'b1;
          end
        end
        default: begin
          s_next.cfg_touched = s_reg.cfg_touched; // writes to holes ignored
        end
      endcase
    end
    if (txl.valid && txl.ready) s_next.tx_full = 1'b0;
    if (pop) s_next.rx_full = 1'b0;
    // receiver, mid-bit sampling
    case (s_reg.rx_st)
      VSB_IDLE: begin
        if (vcom_en && !rxd) begin
          s_next.rx_st = VSB_START;
          s_next.rx_cnt = {1'b0, s_reg.div[DIV_W-1:1]};
        end
      end
      VSB_START: begin
        if (s_reg.rx_cnt != '0) begin
          s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        end else if (rxd) begin
          s_next.rx_st = VSB_IDLE; // glitch, not a start bit
        end else begin
          s_next.rx_st = VSB_DATA;
          s_next.rx_bit = 3'h0;
          s_next.rx_cnt = s_reg.div - 1'b1;
        end
      end
      VSB_DATA: begin
        if (s_reg.rx_cnt != '0) begin
          s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        end else begin
          s_next.rx_shf = {rxd, s_reg.rx_shf[7:1]};
          s_next.rx_cnt = s_reg.div - 1'b1;
          if (s_reg.rx_bit == 3'h7) s_next.rx_st = VSB_STOP;
          s_next.rx_bit = s_reg.rx_bit + 1'b1;
        end
      end
      VSB_STOP: begin
        if (s_reg.rx_cnt != '0) begin
          s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        end else begin
          s_next.rx_st = VSB_IDLE; // bad stop bit drops the byte
          // store after pop so a byte in the same cycle is not lost
          if (rx_store && (!s_reg.rx_full || pop)) begin
            s_next.rx_buf = s_reg.rx_shf;
            s_next.rx_full = 1'b1;
          end else if (rx_store) begin
            s_next.ovr = 1'b1; // set wins over a clear in this cycle
          end
        end
      end
      default: s_next.rx_st = VSB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.mode <= MODE_RESET;
      s_reg.baud <= BAUD_RESET;
      s_reg.div <= DIV_RESET;
      s_reg.rx_st <= VSB_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  vsb_uart_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .tx(txl.ser),
    .txd(txd)
  );

  // checks
  sequence rx_done_s;
    (s_reg.rx_st == VSB_STOP) && (s_reg.rx_cnt == '0) && rx_store && !s_reg.rx_full;
  endsequence
  sequence rx_held_s;
    s_reg.rx_full && !cts_o;
  endsequence

  a_cfg_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_reg.cfg_touched |-> (s_reg.baud == BAUD_RESET && s_reg.mode == MODE_RESET && !cts_oe))
    else $error("config left reset defaults without a write");
  a_baud_range: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg.baud >= BAUD_MIN && s_reg.baud <= BAUD_MAX && s_reg.div == vsb_div(s_reg.baud))
    else $error("bit rate outside the supported set");
  a_cts_full: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done_s |=> rx_held_s)
    else $error("clear-to-send not dropped on a full buffer");
  a_rts_holdoff: assert property (@(posedge hclk) disable iff (!hresetn)
    (hon_rts && !rts_n_free) |-> !(txl.valid && txl.ready))
    else $error("character started while target refused");
  a_rts_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (!hon_rts && s_reg.tx_full && vcom_en && txl.ready) |=> !s_reg.tx_full && !txd)
    else $error("byte held although request-to-send is ignored");
  a_cts_drive_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.ph_wr && s_reg.ph_addr == OFF_CTRL) |=> (cts_oe == $past(hwdata[CTRL_MODE_LSB])))
    else $error("clear-to-send drive does not follow the mode");
  a_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (!vcom_en && s_reg.rx_st == VSB_IDLE) |=> (s_reg.rx_st == VSB_IDLE) && !$rose(!txl.ready))
    else $error("data passed while the bridge was disabled");
  a_rx_forward: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done_s |=> (s_reg.rx_buf == $past(s_reg.rx_shf)) ##1 s_reg.rx_full)
    else $error("received byte not placed in the buffer");
  a_one_channel: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && aoff != act_off && (aoff == OFF_DATA_USB || aoff == OFF_DATA_NET))
    |=> s_reg.rdata == 32'h0 && ($past(s_reg.rx_full) -> s_reg.rx_full))
    else $error("inactive channel touched the data path");
  a_tx_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (txl.valid && txl.ready) |=> !txd ##1 !txd)
    else $error("character did not begin with a low start bit");
endmodule

// ===== vsb_target_model.sv
// Purpose: target-side uart model facing the serial bridge.
// Assumes: bit time in hclk cycles is set by the bench in div.
// Notes: a frame once begun is always received in full.
`timescale 1ns/1ps
module vsb_target_model (
  input wire logic hclk, // system clock
  input wire logic txd, // serial line from the bridge
  input wire logic cts_line, // resolved clear-to-send level
  output logic rxd // serial line toward the bridge
);
  int div = 87; // cycles per bit, 115200 at reset
  logic hs = 1'b0; // firmware handshake enabled
  logic [7:0] rx_q[$]; // characters received
  int bad = 0; // frames with a low stop bit
  initial rxd = 1'b1; // line idles high
  // one character; waits for clear-to-send when handshake is on
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    // bounded, so a stuck flow line ends the run as a clear-to-send timeout
    while (hs && cts_line !== 1'b1) begin
      if (n >= 20000) virtual_serial_bridge_uart_bench.fail("clear-to-send");
      @(posedge hclk);
      n++;
    end
    @(posedge hclk);
    rxd <= 1'b0;
    repeat (div) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (div) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat (div) @(posedge hclk);
  endtask
  // receiver samples mid-bit; it still takes a byte after flow hold
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge txd);
      repeat (div / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge hclk);
        d[i] = txd;
      end
      repeat (div) @(posedge hclk);
      if (txd === 1'b1) begin
        rx_q.push_back(d);
      end else begin
        bad++;
      end
    end
  end
endmodule

// ===== virtual_serial_bridge_uart_bench.sv
// Purpose: self-checking bench for the serial bridge.
// Assumes: zero wait state slave, bus ready fed from hreadyout.
// Notes: clear-to-send pulled high on the target side when undriven.
`timescale 1ns/1ps
module virtual_serial_bridge_uart_bench;
  import vsb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus controls
  logic [31:0] haddr, hwdata, hrdata; // bus address and data
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize; // transfer size
  logic rxd, txd, cts_o, cts_oe, rts_n_free, vcom_en; // serial pins
  logic [31:0] r; // last read word
  int error_cnt = 0;
  int checks = 0;
  wire cts_line = cts_oe ? cts_o : 1'b1; // pull-up when released
  localparam logic [19:0] RATES [8] = '{20'h02580, 20'h04b00, 20'h09600,
    20'h0e100, 20'h1c200, 20'h38400, 20'h70800, 20'he1000};
  vsb_bridge dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rxd(rxd), .txd(txd), .cts_o(cts_o), .cts_oe(cts_oe),
    .rts_n_free(rts_n_free), .vcom_en(vcom_en));
  vsb_target_model tgt (.hclk(hclk), .txd(txd), .cts_line(cts_line), .rxd(rxd));
  // verdict and end of run
  task summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task fail(input string what);
    error_cnt++;
    $display("ERROR %0t timeout %s", $time, what);
    summarize();
  endtask
  // next edge with ready high, bounded
  task rdy_edge;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) fail("bus ready");
      @(posedge hclk);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [2:0] sz = 3'h2, input logic sel = 1'b1);
    @(posedge hclk);
    hsel <= sel;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= sz;
    rdy_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge();
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h0);
    check(r, exp, what);
  endtask
  function automatic logic [31:0] stat(input logic [5:0] b);
    return {NET_PORT, 10'h0, b};
  endfunction
  // byte must reach the target model
  task tx_chk(input logic [7:0] exp);
    int n;
    n = 0;
    while (tgt.rx_q.size() == 0) begin
      n++;
      if (n > 20000) fail("target byte");
      @(posedge hclk);
    end
    check({24'h0, tgt.rx_q.pop_front()}, {24'h0, exp}, "byte at target");
  endtask
  task t_reset;
    check({31'h0, txd}, 32'h1, "idle txd");
    check({31'h0, cts_oe}, 32'h0, "cts released");
    rd_chk(OFF_CTRL, 32'h0, "ctrl reset");
    rd_chk(OFF_BAUD, 32'h0001c200, "baud reset");
    rd_chk(OFF_STAT, stat(6'h30), "stat reset");
    rd_chk(8'h20, 32'h0, "unmapped");
    tgt.send(8'h5a);
    rd_chk(OFF_DATA_USB, 32'h0000015a, "rx 115200");
    rd_chk(OFF_DATA_USB, 32'h0000005a, "popped");
    wr(OFF_DATA_USB, 32'h000000a6);
    tx_chk(8'ha6);
  endtask
  task t_baud;
    wr(OFF_BAUD, 32'h000004d2);
    rd_chk(OFF_BAUD, 32'h0001c200, "bad rate kept");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_BAUD, {12'h0, RATES[i]});
      rd_chk(OFF_BAUD, {12'h0, RATES[i]}, "rate");
    end
    tgt.div = (CLK_HZ + 921600 / 2) / 921600;
    wr(OFF_DATA_USB, 32'h000000c3);
    tx_chk(8'hc3);
    tgt.send(8'h81);
    rd_chk(OFF_DATA_USB, 32'h00000181, "rx fast");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, m);
      repeat (2) @(posedge hclk);
      check({31'h0, cts_oe}, m & 1, "cts drive");
      if (m[0]) begin
        tgt.send(8'h11);
        repeat (2) @(posedge hclk);
        check({31'h0, cts_o}, 32'h0, "cts low full");
        if (m == 1) begin
          // target firmware handshake on: next byte must wait for clear-to-send
          tgt.hs = 1'b1;
          fork
            tgt.send(8'h22);
          join_none
          repeat (300) @(posedge hclk);
          rd_chk(OFF_STAT, stat(6'h31), "target paused");
        end
        rd_chk(OFF_DATA_USB, 32'h00000111, "rx held");
        repeat (2) @(posedge hclk);
        check({31'h0, cts_o}, 32'h1, "cts high again");
        if (m == 1) begin
          repeat (300) @(posedge hclk);
          rd_chk(OFF_DATA_USB, 32'h00000122, "sent on cts");
          tgt.hs = 1'b0;
        end
      end
    end
  endtask
  task t_ovr;
    wr(OFF_CTRL, 32'h0);
    tgt.send(8'h01);
    tgt.send(8'h02);
    rd_chk(OFF_STAT, stat(6'h39), "overrun set");
    wr(OFF_STAT, 32'h00000008);
    rd_chk(OFF_STAT, stat(6'h31), "overrun clear");
    rd_chk(OFF_DATA_USB, 32'h00000101, "first kept");
  endtask
  task t_rts;
    int n;
    wr(OFF_CTRL, 32'h2);
    @(posedge hclk);
    rts_n_free <= 1'b0;
    wr(OFF_DATA_USB, 32'h00000066);
    n = 0;
    repeat (400) begin
      @(posedge hclk);
      n += (txd === 1'b0);
    end
    check(n, 0, "held by rts");
    rd_chk(OFF_STAT, stat(6'h12), "byte waiting");
    rts_n_free <= 1'b1;
    tx_chk(8'h66);
    wr(OFF_DATA_USB, 32'h00000099);
    n = 0;
    while (txd !== 1'b0) begin
      n++;
      if (n > 200) fail("start bit");
      @(posedge hclk);
    end
    rts_n_free <= 1'b0;
    wr(OFF_DATA_USB, 32'h00000042);
    tx_chk(8'h99);
    repeat (400) @(posedge hclk);
    check(tgt.rx_q.size(), 0, "second held");
    rts_n_free <= 1'b1;
    tx_chk(8'h42);
    wr(OFF_CTRL, 32'h0);
    @(posedge hclk);
    rts_n_free <= 1'b0;
    wr(OFF_DATA_USB, 32'h00000024);
    tx_chk(8'h24);
    rts_n_free <= 1'b1;
  endtask
  task t_enable;
    @(posedge hclk);
    vcom_en <= 1'b0;
    tgt.send(8'h77);
    rd_chk(OFF_STAT, stat(6'h20), "rx gated");
    wr(OFF_DATA_USB, 32'h00000055);
    repeat (400) @(posedge hclk);
    check(tgt.rx_q.size(), 0, "tx gated");
    vcom_en <= 1'b1;
    tx_chk(8'h55);
  endtask
  task t_chan;
    wr(OFF_CTRL, 32'h4);
    tgt.send(8'h3e);
    rd_chk(OFF_DATA_USB, 32'h0, "usb silent");
    rd_chk(OFF_DATA_NET, 32'h0000013e, "socket rx");
    wr(OFF_DATA_USB, 32'h00000010);
    repeat (400) @(posedge hclk);
    check(tgt.rx_q.size(), 0, "usb tx dropped");
    wr(OFF_DATA_NET, 32'h00000020);
    tx_chk(8'h20);
    check(tgt.bad, 0, "stop bits");
  endtask
  // odd bus transfers are ignored; a mid-run reset restores the defaults
  task t_bus;
    ahb(1'b1, OFF_CTRL, 32'h3, 3'h0, 1'b1);
    ahb(1'b1, OFF_CTRL, 32'h3, 3'h2, 1'b0);
    rd_chk(OFF_CTRL, 32'h4, "odd transfers ignored");
    wr(OFF_BAUD, 32'h00002580);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    check({31'h0, cts_oe}, 32'h0, "cts released again");
    rd_chk(OFF_BAUD, 32'h0001c200, "baud after reset");
    rd_chk(OFF_CTRL, 32'h0, "ctrl after reset");
    tgt.div = 87;
    tgt.send(8'h3c);
    rd_chk(OFF_DATA_USB, 32'h0000013c, "rx after reset");
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // reset, then scenarios in order
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    rts_n_free = 1'b1;
    vcom_en = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_baud();
    t_modes();
    t_ovr();
    t_rts();
    t_enable();
    t_chan();
    t_bus();
    summarize();
  end
endmodule
